// [core/cmi_defs.svh]
`ifndef CMI_DEFS_SVH
`define CMI_DEFS_SVH

`define CMI_FLAG_BASE    8'h04
`define CMI_CFG_BASE     8'h08
`define CMI_CFG_LAST     8'h10
`define CMI_MASK_A_OFS   8'h08
`define CMI_MASK_B_OFS   8'h09
`define CMI_MASK_C_OFS   8'h0a
`define CMI_MASK_D_OFS   8'h0b
`define CMI_VBAT_OFS     8'h0c
`define CMI_FCC_OFS      8'h0d
`define CMI_CTRL_A_OFS   8'h0e
`define CMI_CTRL_B_OFS   8'h0f
`define CMI_GEN_OFS      8'h10

`define CMI_MASK_A_RST   8'h84
`define CMI_MASK_B_RST   8'h07
`define CMI_MASK_C_RST   8'hc0
`define CMI_MASK_D_RST   8'h00
`define CMI_VBAT_RST     8'h46
`define CMI_FCC_RST      8'h05
`define CMI_CTRL_A_RST   8'h70
`define CMI_CTRL_B_RST   8'h45
`define CMI_GEN_RST      8'h10

`define CMI_MASK_A_WM    8'hc7
`define CMI_MASK_D_WM    8'h0f
`define CMI_VBAT_WM      8'h7f
`define CMI_GEN_WM       8'h7f
`define CMI_FULL_WM      8'hff
`define CMI_FCC_WD       8'hff
`define CMI_CTRL_A_WD    8'h30
`define CMI_NO_WD        8'h00

`define CMI_FLAG_IMPL    32'hffff_ffc7
`define CMI_ADC_DONE_BIT 11
`define CMI_CHG_BIT      23

`define CMI_VBAT_MAX     7'h73
`define CMI_VBAT_BASE_MV 3500
`define CMI_VBAT_STEP_MV 10
`define CMI_FCC_LOW_TOP  30
`define CMI_FCC_LOW_OFS  5
`define CMI_FCC_KNEE     31
`define CMI_FCC_HI_MA    40
`define CMI_FCC_HI_STEP  10
`define CMI_SEL_OFF      2'b11

`endif

// [core/cmi_i2c_slave.sv]
`timescale 1ns/1ps
module cmi_i2c_slave
    import cmi_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h6a
)(
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    output cmi_req_s        req,
    input  wire logic [7:0] rdata
);
    logic [1:0]     scl_sync;
    logic [1:0]     sda_sync;
    logic           scl_q;
    logic           sda_q;
    logic [7:0]     shift;
    logic [7:0]     ptr;
    logic [3:0]     cnt;
    logic           first;
    logic           rnw;
    cmi_i2c_state_e state;
    logic           rise;
    logic           fall;
    logic           start_c;
    logic           stop_c;

    assign sda_out = 1'b0;
    assign rise    = scl_sync[1] & ~scl_q;
    assign fall    = ~scl_sync[1] & scl_q;
    assign start_c = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
    assign stop_c  = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            scl_sync <= 2'b11;
            sda_sync <= 2'b11;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
        end
        else
        begin
            scl_sync <= {scl_sync[0], scl};
            sda_sync <= {sda_sync[0], sda_in};
            scl_q    <= scl_sync[1];
            sda_q    <= sda_sync[1];
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state    <= ST_IDLE;
            shift    <= 8'h00;
            ptr      <= 8'h00;
            cnt      <= 4'h0;
            first    <= 1'b0;
            rnw      <= 1'b0;
            sda_oe_n <= 1'b1;
            req      <= '0;
        end
        else
        begin
            req.wr <= 1'b0;
            req.rd <= 1'b0;
            if (start_c)
            begin
                state    <= ST_ADDR;
                cnt      <= 4'h0;
                sda_oe_n <= 1'b1;
            end
            else if (stop_c)
            begin
                state    <= ST_IDLE;
                sda_oe_n <= 1'b1;
            end
            else
            begin
                case (state)
                ST_ADDR, ST_WR:
                begin
                    if (rise)
                    begin
                        shift <= {shift[6:0], sda_sync[1]};
                        cnt   <= cnt + 4'h1;
                    end
                    else if (fall && cnt == 4'h8)
                    begin
                        cnt <= 4'h0;
                        if (state == ST_ADDR)
                        begin
                            rnw      <= shift[0];
                            sda_oe_n <= !(shift[7:1] == DEV_ADDR);
                            state    <= (shift[7:1] == DEV_ADDR) ? ST_ACK_A : ST_IDLE;
                            first    <= 1'b1;
                        end
                        else
                        begin
                            sda_oe_n <= 1'b0;
                            state    <= ST_ACK_W;
                            first    <= 1'b0;
                            if (first)
                                ptr <= shift;
                            else
                            begin
                                req.wr    <= 1'b1;
                                req.addr  <= ptr;
                                req.wdata <= shift;
                                ptr       <= ptr + 8'h01;
                            end
                        end
                    end
                end
                ST_ACK_A, ST_ACK_W, ST_ACK_R:
                begin
                    if (state == ST_ACK_R && rise && sda_sync[1])
                        state <= ST_IDLE;
                    else if (fall)
                    begin
                        sda_oe_n <= 1'b1;
                        if (state == ST_ACK_W || !rnw)
                            state <= ST_WR;
                        else
                        begin
                            req.rd   <= 1'b1;
                            req.addr <= ptr;
                            ptr      <= ptr + 8'h01;
                            state    <= ST_LOAD;
                        end
                    end
                end
                ST_LOAD:
                begin
                    shift    <= rdata;
                    sda_oe_n <= rdata[7];
                    cnt      <= 4'h1;
                    state    <= ST_RD;
                end
                ST_RD:
                begin
                    if (fall)
                    begin
                        shift    <= {shift[6:0], 1'b0};
                        sda_oe_n <= (cnt == 4'h8) ? 1'b1 : shift[6];
                        cnt      <= cnt + 4'h1;
                        if (cnt == 4'h8)
                            state <= ST_ACK_R;
                    end
                end
                default:
                    state <= ST_IDLE;
                endcase
            end
        end
    end

endmodule : cmi_i2c_slave

// [core/cmi_pkg.sv]
package cmi_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cmi_req_s;

    typedef struct packed {
        logic [6:0]  battery_target_voltage;
        logic [12:0] battery_target_mv;
        logic        charge_inhibit;
        logic [6:0]  fast_charge_current_code;
        logic [10:0] fast_charge_ma;
        logic        power_path_regulation_off;
        logic        precharge_current_select;
        logic [1:0]  termination_current_select;
        logic        termination_en;
        logic [1:0]  input_voltage_regulation_level;
        logic        input_voltage_regulation_en;
        logic [1:0]  thermal_regulation_threshold;
        logic        thermal_regulation_en;
        logic [1:0]  battery_discharge_limit;
        logic [2:0]  battery_depletion_threshold;
        logic        short_battery_trickle_current;
        logic [1:0]  sequence_delay_sel;
        logic [6:0]  sequence_delay_ms;
    } cmi_cfg_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_ACK_A = 3'b010,
        ST_WR    = 3'b011,
        ST_ACK_W = 3'b100,
        ST_LOAD  = 3'b101,
        ST_RD    = 3'b110,
        ST_ACK_R = 3'b111
    } cmi_i2c_state_e;

endpackage : cmi_pkg

// [core/cmi_regs_top.sv]
// Notes on behaviour
// - Mask bit 0 lets its event drive the alert; 1 suppresses it.
// - First mask register resets to 84h; bits 5 to 3 read zero.
// - Second mask register resets to 07h.
// - Conversion-done event only counts while the converter is in one-shot mode.
// - Charge-state mask resets set; cleared, every state change alerts.
// - Third mask register resets to C0h.
// - Fourth mask register: four masks in bits 3..0, reset 00h, upper bits zero.
// - Battery target is 3500mV plus 10mV per code, reset 46h, clamped at 73h.
// - Fast-charge current is code plus 5mA, then 40mA plus 10mA per step past 31.
// - Charge inhibit stops charging; it, current code, termination restore on watchdog.
// - Precharge is twice termination when 0, equal when 1, reset 1.
// - Termination select: off, 5, 10, 20 percent; reset 11.
// - Input-voltage regulation: 4.2, 4.5, 4.7V or off; reset 00.
// - Thermal regulation: 100, 80, 60degC or off; reset 00.
// - Discharge limit: 500, 1000, 1500, 3250mA; reset 01.
// - Depletion threshold codes map 3.0V down to 2.1V; reset 000.
// - Short-battery trickle current: 8mA at 0, 1mA at 1; reset 1.
// - Sequence step delay: 1, 4, 16, 64ms; reset 01.
// - Reading a flag register clears its flags.
`timescale 1ns/1ps
`include "cmi_defs.svh"
module cmi_regs_top
    import cmi_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h6a
)(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        scl,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    input  wire logic [31:0] event_pulse,
    input  wire logic [1:0]  charge_state,
    input  wire logic        adc_one_shot,
    input  wire logic        reg_reset,
    input  wire logic        wd_expire,
    output logic             alert_n,
    output cmi_cfg_s         cfg
);
    localparam logic [7:0] RST_V [0:8] = '{
        `CMI_MASK_A_RST, `CMI_MASK_B_RST, `CMI_MASK_C_RST,
        `CMI_MASK_D_RST, `CMI_VBAT_RST, `CMI_FCC_RST,
        `CMI_CTRL_A_RST, `CMI_CTRL_B_RST, `CMI_GEN_RST};
    localparam logic [7:0] WR_M [0:8] = '{
        `CMI_MASK_A_WM, `CMI_FULL_WM, `CMI_FULL_WM,
        `CMI_MASK_D_WM, `CMI_VBAT_WM, `CMI_FULL_WM,
        `CMI_FULL_WM, `CMI_FULL_WM, `CMI_GEN_WM};
    localparam logic [7:0] WD_M [0:8] = '{
        `CMI_NO_WD, `CMI_NO_WD, `CMI_NO_WD,
        `CMI_NO_WD, `CMI_NO_WD, `CMI_FCC_WD,
        `CMI_CTRL_A_WD, `CMI_NO_WD, `CMI_NO_WD};

    cmi_req_s    req;
    logic [7:0]  rdata;
    logic [7:0]  cfg_reg [0:8];
    logic [3:0]  cfg_idx;
    logic        cfg_hit;
    logic        flag_hit;
    logic [31:0] flags;
    logic [31:0] flag_clr;
    logic [31:0] flag_set;
    logic [31:0] mask_vec;
    logic [1:0]  chg_q;
    logic        chg_seen;
    logic        chg_change;
    logic [6:0]  vcode;
    logic [6:0]  icode;

    cmi_i2c_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_i2c (
        .clock    (clock),
        .reset    (reset),
        .scl      (scl),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe_n (sda_oe_n),
        .req      (req),
        .rdata    (rdata)
    );

    assign cfg_idx  = 4'(req.addr - `CMI_CFG_BASE);
    assign cfg_hit  = req.addr >= `CMI_CFG_BASE && req.addr <= `CMI_CFG_LAST;
    assign flag_hit = req.addr >= `CMI_FLAG_BASE && req.addr < `CMI_CFG_BASE;

    // Reserved bits are simply never stored, so they cannot read back set
    generate
        for (genvar i = 0; i < 9; i++)
        begin : g_cfg
            always_ff @(posedge clock)
            begin
                if (reset || reg_reset)
                    cfg_reg[i] <= RST_V[i];
                else if (wd_expire)
                    cfg_reg[i] <= (cfg_reg[i] & ~WD_M[i]) | (RST_V[i] & WD_M[i]);
                else if (req.wr && cfg_hit && cfg_idx == 4'(i))
                    cfg_reg[i] <= req.wdata & WR_M[i];
            end
        end
    endgenerate

    // Status registers below the flags are outside this bank and read zero
    always_comb
    begin
        rdata = 8'h00;
        if (flag_hit)
            rdata = flags[8*req.addr[1:0] +: 8];
        else if (cfg_hit)
            rdata = cfg_reg[cfg_idx];
    end

    always_comb
    begin
        flag_clr = '0;
        if (req.rd && flag_hit)
            flag_clr[8*req.addr[1:0] +: 8] = 8'hff;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            chg_q    <= 2'b00;
            chg_seen <= 1'b0;
        end
        else
        begin
            chg_q    <= charge_state;
            chg_seen <= 1'b1;
        end
    end

    // First cycle after reset has no previous state to compare against
    assign chg_change = chg_seen && chg_q != charge_state;

    always_comb
    begin
        flag_set = event_pulse & `CMI_FLAG_IMPL;
        flag_set[`CMI_ADC_DONE_BIT] = event_pulse[`CMI_ADC_DONE_BIT] & adc_one_shot;
        flag_set[`CMI_CHG_BIT] = event_pulse[`CMI_CHG_BIT] | chg_change;
    end

    // Set beats clear so an event during the read is kept for the next one
    always_ff @(posedge clock)
    begin
        if (reset)
            flags <= '0;
        else
            flags <= (flags & ~flag_clr) | flag_set;
    end

    // Same bit position in mask and flag; flag bits 31..28 have no mask
    assign mask_vec = {cfg_reg[3], cfg_reg[2], cfg_reg[1], cfg_reg[0]};

    always_ff @(posedge clock)
    begin
        if (reset)
            alert_n <= 1'b1;
        else
            alert_n <= ~|(flags & ~mask_vec);
    end

    assign vcode = (cfg_reg[4][6:0] > `CMI_VBAT_MAX) ? `CMI_VBAT_MAX : cfg_reg[4][6:0];
    assign icode = cfg_reg[5][6:0];

    always_ff @(posedge clock)
    begin
        if (reset)
            cfg <= '0;
        else
        begin
            cfg.battery_target_voltage <= vcode;
            cfg.battery_target_mv <=
                13'(`CMI_VBAT_BASE_MV + `CMI_VBAT_STEP_MV * vcode);
            cfg.charge_inhibit <= cfg_reg[5][7];
            cfg.fast_charge_current_code <= icode;
            if (icode <= 7'(`CMI_FCC_LOW_TOP))
                cfg.fast_charge_ma <= 11'(icode + `CMI_FCC_LOW_OFS);
            else
                cfg.fast_charge_ma <= 11'(`CMI_FCC_HI_MA
                    + (icode - `CMI_FCC_KNEE) * `CMI_FCC_HI_STEP);
            cfg.power_path_regulation_off <= cfg_reg[6][7];
            cfg.precharge_current_select <= cfg_reg[6][6];
            cfg.termination_current_select <= cfg_reg[6][5:4];
            cfg.termination_en <= cfg_reg[6][5:4] != 2'b00;
            cfg.input_voltage_regulation_level <= cfg_reg[6][3:2];
            cfg.input_voltage_regulation_en <= cfg_reg[6][3:2] != `CMI_SEL_OFF;
            cfg.thermal_regulation_threshold <= cfg_reg[6][1:0];
            cfg.thermal_regulation_en <= cfg_reg[6][1:0] != `CMI_SEL_OFF;
            cfg.battery_discharge_limit <= cfg_reg[7][7:6];
            cfg.battery_depletion_threshold <= cfg_reg[7][5:3];
            cfg.short_battery_trickle_current <= cfg_reg[7][2];
            cfg.sequence_delay_sel <= cfg_reg[7][1:0];
            cfg.sequence_delay_ms <= 7'(7'h01 << (2 * cfg_reg[7][1:0]));
        end
    end

    sequence s_reset_rel;
        reset ##1 !reset;
    endsequence

    property p_mask_a_reset;
        @(posedge clock) s_reset_rel |-> cfg_reg[0] == 8'h84;
    endproperty
    a_mask_a_reset: assert property (p_mask_a_reset)
        else $error("first mask register reset value wrong");

    property p_mask_b_reset;
        @(posedge clock) s_reset_rel |-> cfg_reg[1] == 8'h07;
    endproperty
    a_mask_b_reset: assert property (p_mask_b_reset)
        else $error("second mask register reset value wrong");

    property p_mask_c_reset;
        @(posedge clock) s_reset_rel |-> cfg_reg[2] == 8'hc0 && cfg_reg[6] == 8'h70;
    endproperty
    a_mask_c_reset: assert property (p_mask_c_reset)
        else $error("third mask or control reset value wrong");

    property p_reserved_zero;
        @(posedge clock) disable iff (reset)
            req.wr |=> cfg_reg[3][7:4] == 4'h0 && cfg_reg[0][5:3] == 3'b000
                && cfg_reg[4][7] == 1'b0 && cfg_reg[8][7] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit stored a written one");

    property p_vbat_clamp;
        @(posedge clock) disable iff (reset)
            cfg_reg[4][6:0] > 7'h73 |-> ##1 cfg.battery_target_mv == 13'd4650;
    endproperty
    a_vbat_clamp: assert property (p_vbat_clamp)
        else $error("battery target not clamped");

    property p_wd_restore;
        @(posedge clock) disable iff (reset || reg_reset)
            wd_expire |=> cfg_reg[5] == 8'h05 && cfg_reg[6][5:4] == 2'b11;
    endproperty
    a_wd_restore: assert property (p_wd_restore)
        else $error("watchdog did not restore charge fields");

    property p_flag_clear;
        @(posedge clock) disable iff (reset)
            req.rd && req.addr == 8'h04 && event_pulse[7:0] == 8'h00 |=> flags[7:0] == 8'h00;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag byte not cleared by read");

    property p_adc_gate;
        @(posedge clock) disable iff (reset)
            !adc_one_shot && !flags[11] && !(req.rd && req.addr == 8'h05) |=> !flags[11];
    endproperty
    a_adc_gate: assert property (p_adc_gate)
        else $error("conversion flag set outside one-shot mode");

    sequence s_unmasked;
        |(flags & ~mask_vec);
    endsequence

    property p_alert;
        @(posedge clock) disable iff (reset) s_unmasked |=> !alert_n;
    endproperty
    a_alert: assert property (p_alert)
        else $error("unmasked event did not assert alert");

    property p_masked_quiet;
        @(posedge clock) disable iff (reset)
            (flags & ~mask_vec) == 32'h0000_0000 |=> alert_n;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("alert asserted with all events masked");

    property p_chg_alert;
        @(posedge clock) disable iff (reset || reg_reset)
            chg_change && !cfg_reg[2][7] && !req.wr |-> ##2 !alert_n;
    endproperty
    a_chg_alert: assert property (p_chg_alert)
        else $error("charge state change did not alert");

    property p_mask_d_reset;
        @(posedge clock) s_reset_rel |-> cfg_reg[3] == 8'h00;
    endproperty
    a_mask_d_reset: assert property (p_mask_d_reset)
        else $error("mask d reset wrong");

    property p_target_reset;
        @(posedge clock) s_reset_rel |-> cfg_reg[4] == 8'h46;
    endproperty
    a_target_reset: assert property (p_target_reset)
        else $error("target reset wrong");

    property p_ctrl_b_reset;
        @(posedge clock) s_reset_rel |-> cfg_reg[7] == 8'h45;
    endproperty
    a_ctrl_b_reset: assert property (p_ctrl_b_reset)
        else $error("control b reset wrong");

    property p_reg_reset;
        @(posedge clock) reg_reset |=> cfg_reg[5] == 8'h05 && cfg_reg[6] == 8'h70;
    endproperty
    a_reg_reset: assert property (p_reg_reset)
        else $error("register reset missed");

    property p_inhibit;
        @(posedge clock) disable iff (reset) 1'b1 |=> cfg.charge_inhibit == $past(cfg_reg[5][7]);
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("inhibit not shown");

    property p_term_en;
        @(posedge clock) disable iff (reset)
            1'b1 |=> cfg.termination_en == ($past(cfg_reg[6][5:4]) != 2'b00);
    endproperty
    a_term_en: assert property (p_term_en)
        else $error("termination enable wrong");

    property p_knee;
        @(posedge clock) disable iff (reset) cfg_reg[5][6:0] == 7'h1f |=> cfg.fast_charge_ma == 11'h028;
    endproperty
    a_knee: assert property (p_knee)
        else $error("knee current wrong");

    property p_delay_max;
        @(posedge clock) disable iff (reset) cfg_reg[7][1:0] == 2'b11 |=> cfg.sequence_delay_ms == 7'h40;
    endproperty
    a_delay_max: assert property (p_delay_max)
        else $error("longest delay wrong");

    property p_masked_kept;
        @(posedge clock) disable iff (reset) event_pulse[2] |=> flags[2];
    endproperty
    a_masked_kept: assert property (p_masked_kept)
        else $error("masked flag lost");

    property p_flag_rsvd;
        @(posedge clock) disable iff (reset) 1'b1 |-> flags[5:3] == 3'b000;
    endproperty
    a_flag_rsvd: assert property (p_flag_rsvd)
        else $error("reserved flag set");

endmodule : cmi_regs_top

// [dv/charger_irq_mask_config_regs_tb_top.sv]
`timescale 1ns/1ps
module charger_irq_mask_config_regs_tb_top;
    import cmi_pkg::*;
    logic        clock        = 1'b0;
    logic        reset        = 1'b1;
    logic [31:0] event_pulse  = 32'h0000_0000;
    logic [1:0]  charge_state = 2'h0;
    logic        adc_one_shot = 1'b0;
    logic        reg_reset    = 1'b0;
    logic        wd_expire    = 1'b0;
    logic        scl;
    logic        sda_low;
    logic        sda_oe_n;
    logic        alert_n;
    cmi_cfg_s    cfg;
    // Pull-up on the shared data line
    wire         sda_line     = (sda_low || !sda_oe_n) ? 1'b0 : 1'b1;
    int          miscompares  = 0;
    int          total_checks = 0;
    int          cycles       = 0;
    logic [7:0]  rv;

    cmi_host_model h (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    cmi_regs_top dut (
        .clock(clock), .reset(reset), .scl(scl), .sda_in(sda_line), .sda_out(),
        .sda_oe_n(sda_oe_n), .event_pulse(event_pulse), .charge_state(charge_state),
        .adc_one_shot(adc_one_shot), .reg_reset(reg_reset), .wd_expire(wd_expire),
        .alert_n(alert_n), .cfg(cfg)
    );

    initial
    begin
        forever #50 clock = ~clock;
    end

    task automatic print_verdict();
        if (miscompares == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    // Ceiling is nearly three times the expected bus traffic
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            miscompares++;
            print_verdict();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        h.start();
        h.put_byte(8'hd4);
        h.put_byte(a);
        h.put_byte(d);
        h.stop();
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        h.start();
        h.put_byte(8'hd4);
        h.put_byte(a);
        h.start();
        h.put_byte(8'hd5);
        h.get_byte(d);
        h.stop();
    endtask : rd
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        check(16'(d), 16'(e));
    endtask : rd_chk
    task automatic pulse(input int b);
        event_pulse <= 32'h0000_0001 << b;
        @(posedge clock);
        event_pulse <= 32'h0000_0000;
        repeat (4) @(posedge clock);
    endtask : pulse

    task automatic t_reset_values();
        logic [7:0] e [9] = '{8'h84, 8'h07, 8'hc0, 8'h00, 8'h46, 8'h05, 8'h70, 8'h45, 8'h10};
        for (int i = 0; i < 9; i++)
            rd_chk(8'h08 + 8'(i), e[i]);
        check(16'(cfg.battery_target_mv), 16'h1068);
        check(16'(cfg.fast_charge_ma), 16'h000a);
        check(16'(cfg.sequence_delay_ms), 16'h0004);
    endtask : t_reset_values

    task automatic t_reserved_and_clamp();
        wr(8'h08, 8'hff);
        rd_chk(8'h08, 8'hc7);
        wr(8'h0b, 8'hff);
        rd_chk(8'h0b, 8'h0f);
        wr(8'h0c, 8'hff);
        rd_chk(8'h0c, 8'h7f);
        check(16'(cfg.battery_target_voltage), 16'h0073);
        check(16'(cfg.battery_target_mv), 16'h122a);
        wr(8'h0c, 8'h00);
        check(16'(cfg.battery_target_mv), 16'h0dac);
        rd_chk(8'h11, 8'h00);
    endtask : t_reserved_and_clamp

    task automatic t_charge_current();
        logic [7:0]  c [3] = '{8'h9e, 8'h1f, 8'h7f};
        logic [15:0] m [3] = '{16'h0023, 16'h0028, 16'h03e8};
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h0d, c[i]);
            check(16'(cfg.fast_charge_ma), m[i]);
            check(16'(cfg.charge_inhibit), 16'(c[i][7]));
        end
    endtask : t_charge_current

    task automatic t_control_fields();
        logic [6:0] ms [4] = '{7'd1, 7'd4, 7'd16, 7'd64};
        wr(8'h0e, 8'h8f);
        check(16'({cfg.power_path_regulation_off, cfg.precharge_current_select,
            cfg.termination_current_select, cfg.termination_en,
            cfg.input_voltage_regulation_level, cfg.input_voltage_regulation_en,
            cfg.thermal_regulation_threshold, cfg.thermal_regulation_en}),
            16'h0436);
        wr(8'h0e, 8'h54);
        check(16'({cfg.power_path_regulation_off, cfg.precharge_current_select,
            cfg.termination_en, cfg.input_voltage_regulation_en,
            cfg.thermal_regulation_en}), 16'h000f);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h0f, {2'(i), 3'(i + 4), 1'(i), 2'(i)});
            check(16'({cfg.battery_discharge_limit, cfg.battery_depletion_threshold,
                cfg.short_battery_trickle_current, cfg.sequence_delay_ms}),
                16'({2'(i), 3'(i + 4), 1'(i), ms[i]}));
        end
    endtask : t_control_fields

    task automatic t_restore();
        wr(8'h0d, 8'h9e);
        wr(8'h0e, 8'h0f);
        wd_expire <= 1'b1;
        @(posedge clock);
        wd_expire <= 1'b0;
        repeat (3) @(posedge clock);
        rd_chk(8'h0d, 8'h05);
        rd_chk(8'h0e, 8'h3f);
        check(16'(cfg.charge_inhibit), 16'h0000);
        reg_reset <= 1'b1;
        @(posedge clock);
        reg_reset <= 1'b0;
        repeat (3) @(posedge clock);
        rd_chk(8'h0e, 8'h70);
        rd_chk(8'h0f, 8'h45);
    endtask : t_restore

    task automatic t_events();
        pulse(2);
        check(16'(alert_n), 16'h0001);
        rd_chk(8'h04, 8'h04);
        rd_chk(8'h04, 8'h00);
        pulse(1);
        check(16'(alert_n), 16'h0000);
        wr(8'h08, 8'h86);
        check(16'(alert_n), 16'h0001);
        wr(8'h08, 8'h84);
        check(16'(alert_n), 16'h0000);
        rd_chk(8'h04, 8'h02);
        check(16'(alert_n), 16'h0001);
        pulse(11);
        rd_chk(8'h05, 8'h00);
        adc_one_shot <= 1'b1;
        pulse(11);
        check(16'(alert_n), 16'h0000);
        rd_chk(8'h05, 8'h08);
        wr(8'h0a, 8'h40);
        charge_state <= 2'h2;
        repeat (5) @(posedge clock);
        check(16'(alert_n), 16'h0000);
        rd_chk(8'h06, 8'h80);
    endtask : t_events

    initial
    begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        repeat (3) @(posedge clock);
        t_reset_values();
        t_reserved_and_clamp();
        t_charge_current();
        t_control_fields();
        t_restore();
        t_events();
        check(16'(h.nacks), 16'h0000);
        print_verdict();
    end
endmodule : charger_irq_mask_config_regs_tb_top

// [dv/cmi_host_model.sv]
`timescale 1ns/1ps
module cmi_host_model (
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    // Slow bit cell: 10 clocks low, 10 high, so it stays well above the sync latency
    int nacks = 0;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick
    task automatic put_bit(input logic b);
        sda_low <= ~b;
        tick(5);
        scl <= 1'b1;
        tick(10);
        scl <= 1'b0;
        tick(5);
    endtask : put_bit
    task automatic get_bit(output logic b);
        sda_low <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(5);
        b = sda_line;
        tick(5);
        scl <= 1'b0;
        tick(5);
    endtask : get_bit
    // Also serves as repeated start from a low clock
    task automatic start();
        sda_low <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(10);
        sda_low <= 1'b1;
        tick(10);
        scl <= 1'b0;
        tick(5);
    endtask : start
    task automatic stop();
        sda_low <= 1'b1;
        tick(5);
        scl <= 1'b1;
        tick(10);
        sda_low <= 1'b0;
        tick(10);
    endtask : stop
    task automatic put_byte(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        get_bit(a);
        if (a !== 1'b0)
            nacks++;
    endtask : put_byte
    // Single-byte reads only: always ends with a nack
    task automatic get_byte(output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            get_bit(d[i]);
        put_bit(1'b1);
    endtask : get_byte
endmodule : cmi_host_model
